// *** common/mter_consts.svh ***
// constants of the write-multiple / exception responder
`ifndef MTER_CONSTS_SVH
`define MTER_CONSTS_SVH

// ****************************
// limits and codes
// ****************************
`define MTER_MAX_QTY   125
`define MTER_FC_RD     8'h03
`define MTER_FC_WR     8'h10
`define MTER_EXC_FLAG  8'h80
`define MTER_EXC_NONE  8'h00
`define MTER_EXC_FUNC  8'h01
`define MTER_EXC_ADDR  8'h02
`define MTER_EXC_DATA  8'h03
`define MTER_EXC_BUSY  8'h06
`define MTER_UID_ZERO  8'h00
`define MTER_UID_ALL   8'hff
`define MTER_PROTO_ID  16'h0000
`define MTER_LEN_EXC   16'h0003
`define MTER_LEN_WR    16'h0006
`define MTER_LEN_RD0   16'h0003

// ****************************
// byte positions in a frame
// ****************************
`define MTER_MBAP_BYTES 9'h006
`define MTER_POS_TID_H  9'h000
`define MTER_POS_TID_L  9'h001
`define MTER_POS_PID_H  9'h002
`define MTER_POS_PID_L  9'h003
`define MTER_POS_LEN_H  9'h004
`define MTER_POS_LEN_L  9'h005
`define MTER_POS_UID    9'h006
`define MTER_POS_FC     9'h007
`define MTER_POS_ADR_H  9'h008
`define MTER_POS_ADR_L  9'h009
`define MTER_POS_QTY_H  9'h00a
`define MTER_POS_QTY_L  9'h00b
`define MTER_POS_BCNT   9'h00c
`define MTER_POS_DATA   9'h00d
`define MTER_POS_RDATA  9'h009
`define MTER_RD_BYTES   9'h00c

`endif

// *** common/mter_pkg.sv ***
// types of the write-multiple / exception responder
package mter_pkg;
    typedef enum logic [1:0] {
        ST_RECV,
        ST_CHECK,
        ST_PROC,
        ST_SEND
    } mter_state_e;
    typedef logic [7:0] mter_exc_t;
endpackage

// *** core/mter_hdr_check.sv ***
// header screening of a received query
`timescale 1ns/1ps
`default_nettype none
`include "mter_consts.svh"
module mter_hdr_check import mter_pkg::*; #(
    parameter int MAX_QTY = `MTER_MAX_QTY
) (
    input  wire logic [8:0]  cnt,
    input  wire logic [15:0] pid,
    input  wire logic [15:0] len,
    input  wire logic [7:0]  uid,
    input  wire logic [7:0]  fc,
    input  wire logic [15:0] qty,
    input  wire logic [7:0]  bcnt,
    input  wire logic        ovf,
    input  wire logic        busy,
    output logic             drop,
    output mter_exc_t        exc
);
    logic [15:0] body_len;
    logic [15:0] two_qty;

    always_comb begin
        body_len = 16'(cnt) - 16'(`MTER_MBAP_BYTES);
        two_qty  = {qty[14:0], 1'b0};
        drop     = 1'b0;
        exc      = `MTER_EXC_NONE;
        // a frame too short to echo cannot be answered
        if (cnt <= `MTER_POS_FC || pid != `MTER_PROTO_ID) begin
            drop = 1'b1;
        end else if (uid != `MTER_UID_ZERO && uid != `MTER_UID_ALL) begin
            drop = 1'b1;
        end else if (busy) begin
            exc = `MTER_EXC_BUSY;
        end else if (fc != `MTER_FC_RD && fc != `MTER_FC_WR) begin
            exc = `MTER_EXC_FUNC;
        end else if (len != body_len) begin
            exc = `MTER_EXC_DATA;
        end else if (qty == 16'h0000 || qty > 16'(MAX_QTY)) begin
            exc = `MTER_EXC_DATA;
        end else if (fc == `MTER_FC_WR) begin
            if (16'(bcnt) != two_qty || ovf ||
                body_len != 16'(bcnt) + 16'h0007) begin
                exc = `MTER_EXC_DATA;
            end
        end else if (cnt != `MTER_RD_BYTES) begin
            exc = `MTER_EXC_DATA;
        end
    end
endmodule // mter_hdr_check
`default_nettype wire

// *** core/mter_responder.sv ***
// server message handling: write-multiple, read-multiple, exceptions
`timescale 1ns/1ps
`default_nettype none
`include "mter_consts.svh"
module mter_responder import mter_pkg::*; #(
    parameter int MAX_QTY = `MTER_MAX_QTY
) (
    input  wire logic        clk,
    input  wire logic        nrst,
    input  wire logic        rx_valid,
    input  wire logic [7:0]  rx_data,
    input  wire logic        rx_last,
    output logic             rx_ready,
    output logic             tx_valid,
    output logic [7:0]       tx_data,
    output logic             tx_last,
    input  wire logic        tx_ready,
    input  wire logic        op_busy,
    output logic [15:0]      map_addr,
    output logic             map_rd_en,
    output logic             map_wr_en,
    output logic [15:0]      map_wdata,
    input  wire logic        map_exists,
    input  wire logic        map_readable,
    input  wire logic        map_writable,
    input  wire logic        map_value_ok,
    input  wire logic        map_profile,
    input  wire logic        map_obj_first,
    input  wire logic        map_multi,
    input  wire logic [15:0] map_rdata
);
    localparam int BUF_B = 2 * MAX_QTY;

    if (MAX_QTY < 1 || MAX_QTY > `MTER_MAX_QTY) begin : g_bad_qty
        $error("mter_responder: MAX_QTY out of range");
    end

    // ****************************
    // state
    // ****************************
    typedef struct packed {
        mter_state_e            st;
        logic [8:0]             cnt;
        logic [15:0]            tid;
        logic [15:0]            pid;
        logic [15:0]            len;
        logic [7:0]             uid;
        logic [7:0]             fc;
        logic [15:0]            start;
        logic [15:0]            qty;
        logic [7:0]             bcnt;
        logic                   ovf;
        logic [BUF_B-1:0][7:0]  buf_b;
        logic [7:0]             idx;
        logic [15:0]            addr;
        logic [15:0]            wdata;
        logic                   multi_seen;
        logic                   span_err;
        logic                   val_err;
        logic [7:0]             acc;
        mter_exc_t              exc;
        logic [8:0]             tix;
        logic [7:0]             tbyte;
        logic                   tlast;
    } mter_st_s;

    mter_st_s   s_r;
    mter_st_s   s_nxt;
    logic       ck_drop;
    mter_exc_t  ck_exc;
    logic       is_wr;
    logic       in_proc;
    logic       access;
    logic       span_now;
    logic       stop;
    logic       last_reg;
    logic [15:0] rlen;

    // ****************************
    // helpers
    // ****************************
    function automatic logic [15:0] word_at(input mter_st_s s, input logic [7:0] i);
        logic [8:0] b;
        b = {i, 1'b0};
        word_at = 16'h0000;
        if (int'(b) + 1 < BUF_B) begin
            word_at = {s.buf_b[b], s.buf_b[b + 9'h1]};
        end
    endfunction

    function automatic logic [15:0] resp_len(input mter_st_s s);
        if (s.exc != `MTER_EXC_NONE) begin
            resp_len = `MTER_LEN_EXC;
        end else if (s.fc == `MTER_FC_WR) begin
            resp_len = `MTER_LEN_WR;
        end else begin
            resp_len = `MTER_LEN_RD0 + {s.qty[14:0], 1'b0};
        end
    endfunction

    function automatic logic [7:0] resp_byte(input mter_st_s s, input logic [8:0] i);
        logic [15:0] l;
        logic [8:0]  k;
        l = resp_len(s);
        k = i - `MTER_POS_RDATA;
        resp_byte = 8'h00;
        case (i)
            `MTER_POS_TID_H: resp_byte = s.tid[15:8];
            `MTER_POS_TID_L: resp_byte = s.tid[7:0];
            `MTER_POS_PID_H: resp_byte = 8'(`MTER_PROTO_ID >> 8);
            `MTER_POS_PID_L: resp_byte = 8'(`MTER_PROTO_ID);
            `MTER_POS_LEN_H: resp_byte = l[15:8];
            `MTER_POS_LEN_L: resp_byte = l[7:0];
            `MTER_POS_UID:   resp_byte = s.uid;
            `MTER_POS_FC: begin
                if (s.exc != `MTER_EXC_NONE) begin
                    resp_byte = s.fc | `MTER_EXC_FLAG;
                end else begin
                    resp_byte = s.fc;
                end
            end
            default: begin
                if (s.exc != `MTER_EXC_NONE) begin
                    resp_byte = s.exc;
                end else if (s.fc == `MTER_FC_WR) begin
                    case (i)
                        `MTER_POS_ADR_H: resp_byte = s.start[15:8];
                        `MTER_POS_ADR_L: resp_byte = s.start[7:0];
                        `MTER_POS_QTY_H: resp_byte = s.qty[15:8];
                        default:         resp_byte = s.qty[7:0];
                    endcase
                end else if (i == `MTER_POS_ADR_H) begin
                    resp_byte = {s.qty[6:0], 1'b0};
                end else if (int'(k) < BUF_B) begin
                    resp_byte = s.buf_b[k];
                end
            end
        endcase
    endfunction

    mter_hdr_check #(.MAX_QTY(MAX_QTY)) u_hdr (
        .cnt  (s_r.cnt),
        .pid  (s_r.pid),
        .len  (s_r.len),
        .uid  (s_r.uid),
        .fc   (s_r.fc),
        .qty  (s_r.qty),
        .bcnt (s_r.bcnt),
        .ovf  (s_r.ovf),
        .busy (op_busy),
        .drop (ck_drop),
        .exc  (ck_exc)
    );

    // ****************************
    // register walk decode
    // ****************************
    always_comb begin
        is_wr    = (s_r.fc == `MTER_FC_WR);
        in_proc  = (s_r.st == ST_PROC);
        access   = map_exists && (is_wr ? map_writable : map_readable);
        // profile objects: a gap or a second object next to a multi one
        span_now = map_profile && (!map_exists || (map_obj_first && s_r.idx != 8'h00 &&
                   (s_r.multi_seen || map_multi)));
        stop     = s_r.span_err || span_now;
        last_reg = (16'(s_r.idx) == s_r.qty - 16'h0001);
        rlen     = resp_len(s_r);
    end

    assign rx_ready  = (s_r.st == ST_RECV);
    assign tx_valid  = (s_r.st == ST_SEND);
    assign tx_data   = s_r.tbyte;
    assign tx_last   = s_r.tlast;
    assign map_addr  = s_r.addr;
    assign map_wdata = s_r.wdata;
    assign map_rd_en = in_proc && !is_wr;
    // writes stop at the end of the first object once a span is seen
    assign map_wr_en = in_proc && is_wr && access && map_value_ok && !stop;

    // ****************************
    // next state
    // ****************************
    always_comb begin
        logic [8:0] d;
        logic [8:0] b;
        d = s_r.cnt - `MTER_POS_DATA;
        b = {s_r.idx, 1'b0};
        s_nxt = s_r;
        case (s_r.st)
            ST_RECV: begin
                if (rx_valid) begin
                    if (s_r.cnt != 9'h1ff) begin
                        s_nxt.cnt = s_r.cnt + 9'h001;
                    end
                    case (s_r.cnt)
                        `MTER_POS_TID_H: s_nxt.tid[15:8]   = rx_data;
                        `MTER_POS_TID_L: s_nxt.tid[7:0]    = rx_data;
                        `MTER_POS_PID_H: s_nxt.pid[15:8]   = rx_data;
                        `MTER_POS_PID_L: s_nxt.pid[7:0]    = rx_data;
                        `MTER_POS_LEN_H: s_nxt.len[15:8]   = rx_data;
                        `MTER_POS_LEN_L: s_nxt.len[7:0]    = rx_data;
                        `MTER_POS_UID:   s_nxt.uid         = rx_data;
                        `MTER_POS_FC:    s_nxt.fc          = rx_data;
                        `MTER_POS_ADR_H: s_nxt.start[15:8] = rx_data;
                        `MTER_POS_ADR_L: s_nxt.start[7:0]  = rx_data;
                        `MTER_POS_QTY_H: s_nxt.qty[15:8]   = rx_data;
                        `MTER_POS_QTY_L: s_nxt.qty[7:0]    = rx_data;
                        `MTER_POS_BCNT:  s_nxt.bcnt        = rx_data;
                        default: begin
                            if (int'(d) < BUF_B) begin
                                s_nxt.buf_b[d] = rx_data;
                            end else begin
                                s_nxt.ovf = 1'b1;
                            end
                        end
                    endcase
                    if (rx_last) begin
                        s_nxt.st = ST_CHECK;
                    end
                end
            end
            ST_CHECK: begin
                s_nxt.cnt        = 9'h000;
                s_nxt.ovf        = 1'b0;
                s_nxt.idx        = 8'h00;
                s_nxt.addr       = s_r.start;
                s_nxt.wdata      = word_at(s_r, 8'h00);
                s_nxt.acc        = 8'h00;
                s_nxt.multi_seen = 1'b0;
                s_nxt.span_err   = 1'b0;
                s_nxt.val_err    = 1'b0;
                s_nxt.exc        = ck_exc;
                s_nxt.tix        = 9'h000;
                s_nxt.tbyte      = s_r.tid[15:8];
                s_nxt.tlast      = 1'b0;
                if (ck_drop) begin
                    s_nxt.st = ST_RECV;
                end else if (ck_exc != `MTER_EXC_NONE) begin
                    s_nxt.st = ST_SEND;
                end else begin
                    s_nxt.st = ST_PROC;
                end
            end
            ST_PROC: begin
                s_nxt.multi_seen = s_r.multi_seen || (map_profile && map_multi);
                s_nxt.span_err   = stop;
                if (access && !stop && (!is_wr || map_value_ok)) begin
                    s_nxt.acc = s_r.acc + 8'h01;
                end
                if (is_wr && access && !map_value_ok) begin
                    s_nxt.val_err = 1'b1;
                end
                if (!is_wr) begin
                    // missing or unreadable registers read as zero
                    s_nxt.buf_b[b]        = access ? map_rdata[15:8] : 8'h00;
                    s_nxt.buf_b[b + 9'h1] = access ? map_rdata[7:0] : 8'h00;
                end
                s_nxt.idx   = s_r.idx + 8'h01;
                s_nxt.addr  = s_r.addr + 16'h0001;
                s_nxt.wdata = word_at(s_r, s_r.idx + 8'h01);
                if (last_reg) begin
                    s_nxt.st = ST_SEND;
                    if (stop) begin
                        s_nxt.exc = `MTER_EXC_ADDR;
                    end else if (s_nxt.acc == 8'h00) begin
                        s_nxt.exc = s_nxt.val_err ? `MTER_EXC_DATA : `MTER_EXC_ADDR;
                    end
                end
            end
            ST_SEND: begin
                if (tx_ready) begin
                    if (s_r.tlast) begin
                        s_nxt.st = ST_RECV;
                    end else begin
                        s_nxt.tix   = s_r.tix + 9'h001;
                        s_nxt.tbyte = resp_byte(s_r, s_r.tix + 9'h001);
                        s_nxt.tlast = ((s_r.tix + 9'h001) == (rlen[8:0] + 9'h005));
                    end
                end
            end
            default: s_nxt.st = ST_RECV;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ****************************
    // checks
    // ****************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    sequence seq_chk_exc;
        s_r.st == ST_CHECK && !ck_drop && ck_exc != `MTER_EXC_NONE;
    endsequence
    sequence seq_send_enter;
        s_r.st == ST_SEND && s_r.tix == 9'h000 && tx_data == s_r.tid[15:8];
    endsequence

    chk_proto_drop: assert property (
        s_r.st == ST_CHECK && s_r.pid != `MTER_PROTO_ID |=> s_r.st == ST_RECV)
        else $error("query with non-zero protocol id was not dropped");
    chk_resp_pid: assert property (
        tx_valid && (s_r.tix == `MTER_POS_PID_H || s_r.tix == `MTER_POS_PID_L)
        |-> tx_data == 8'h00)
        else $error("response protocol id not zero");
    chk_exc_start: assert property (seq_chk_exc |=> seq_send_enter)
        else $error("exception response did not start with transaction id");
    chk_exc_func: assert property (
        tx_valid && s_r.tix == `MTER_POS_FC && s_r.exc != `MTER_EXC_NONE
        |-> tx_data == (s_r.fc | `MTER_EXC_FLAG))
        else $error("exception function byte lacks flag");
    chk_exc_len: assert property (
        tx_valid && s_r.tix == `MTER_POS_LEN_L && s_r.exc != `MTER_EXC_NONE
        |-> tx_data == 8'h03)
        else $error("exception length not three");
    chk_busy_code: assert property (
        s_r.st == ST_CHECK && !ck_drop && op_busy |=> s_r.exc == `MTER_EXC_BUSY)
        else $error("busy query not answered with 06");
    chk_bad_func: assert property (
        s_r.st == ST_CHECK && !ck_drop && !op_busy && s_r.fc != `MTER_FC_RD &&
        s_r.fc != `MTER_FC_WR |=> s_r.exc == `MTER_EXC_FUNC ##1 tx_valid)
        else $error("unsupported function not answered with 01");
    chk_span_stop: assert property (
        in_proc && stop |-> !map_wr_en)
        else $error("write applied past the first object");
    chk_wr_len: assert property (
        tx_valid && s_r.tix == `MTER_POS_LEN_L && s_r.exc == `MTER_EXC_NONE &&
        is_wr |-> tx_data == 8'h06)
        else $error("write reply length not six");
    chk_none_exc: assert property (
        in_proc && last_reg && s_nxt.acc == 8'h00 |=> s_r.exc != `MTER_EXC_NONE)
        else $error("no accessible register but no exception");
endmodule // mter_responder
`default_nettype wire

// *** verification/mter_client_model.sv ***
// client side model: sends query bytes and collects response bytes
`timescale 1ns/1ps
`default_nettype none
module mter_client_model (
    input  wire logic       clk,
    input  wire logic       stall,
    output logic            rx_valid,
    output logic [7:0]      rx_data,
    output logic            rx_last,
    input  wire logic       rx_ready,
    input  wire logic       tx_valid,
    input  wire logic [7:0] tx_data,
    input  wire logic       tx_last,
    output logic            tx_ready
);
    // ****************************
    // idle levels
    // ****************************
    initial begin
        rx_valid = 1'b0;
        rx_data  = 8'h00;
        rx_last  = 1'b0;
    end
    // random stalls from the bench exercise the tx hold behaviour
    assign tx_ready = ~stall;

    // ****************************
    // query sender
    // ****************************
    // bytes change at the falling edge and hold until taken
    task automatic send(input logic [7:0] q[$], output bit ok);
        int n;
        ok = 1'b1;
        foreach (q[i]) begin
            @(negedge clk);
            rx_valid = 1'b1;
            rx_data  = q[i];
            rx_last  = (i == q.size() - 1);
            n = 0;
            // rx_ready only moves at the rising edge, so the low phase shows what is taken
            while (rx_ready !== 1'b1 && n < 50) begin
                @(negedge clk);
                n++;
            end
            if (n >= 50) ok = 1'b0;
            @(posedge clk);
        end
        @(negedge clk);
        rx_valid = 1'b0;
        // released line shows the inverse, never a stale byte
        rx_data  = ~rx_data;
        rx_last  = 1'b0;
    endtask

    // ****************************
    // response collector
    // ****************************
    // bounded: an empty or short queue shows a missing answer
    task automatic recv(output logic [7:0] q[$], input int bound);
        int n;
        bit take;
        bit fin;
        q = {};
        n = 0;
        while (n < bound) begin
            // sample settled values before the edge that takes them
            @(negedge clk);
            #1;
            n++;
            take = (tx_valid === 1'b1 && tx_ready === 1'b1);
            fin  = take && tx_last === 1'b1;
            if (take) q.push_back(tx_data);
            @(posedge clk);
            if (fin) break;
        end
    endtask
endmodule // mter_client_model
`default_nettype wire

// *** verification/mter_responder_tb_top.sv ***
// self-checking bench of the write-multiple / exception responder
`timescale 1ns/1ps
`default_nettype none
module mter_responder_tb_top;
    logic        clk = 1'b0;
    logic        nrst;
    logic        stall = 1'b0;
    logic        op_busy;
    logic        rx_valid, rx_last, rx_ready, tx_valid, tx_last, tx_ready;
    logic [7:0]  rx_data, tx_data;
    logic [15:0] map_addr, map_wdata, map_rdata;
    logic        map_rd_en, map_wr_en, in_obj;
    logic [15:0] mem [4];
    int          mem_ref [4];
    int          n_mismatch = 0;
    int          comparisons = 0;
    int          n_rd = 0;
    logic [31:0] seed = 32'd15;
    logic [31:0] st_seed = 32'd15;

    always #12.5 clk = ~clk;

    // ****************************
    // register map model
    // ****************************
    // one four-register object at 6048, sub-index at 604a write-protected, 604d missing profile
    assign in_obj    = (map_addr[15:2] == 14'h1812);
    assign map_rdata = in_obj ? mem[map_addr[1:0]] : 16'ha5a5;
    initial for (int i = 0; i < 4; i++) begin
        mem[i]     = 16'h1000 + 16'(i);
        mem_ref[i] = 'h1000 + i;
    end
    always @(posedge clk) if (map_rd_en === 1'b1) n_rd <= n_rd + 1;
    always @(posedge clk) begin
        if (map_wr_en === 1'b1 && in_obj && map_addr != 16'h604a) begin
            mem[map_addr[1:0]] <= map_wdata;
        end
    end

    function automatic logic [31:0] step(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    function automatic logic [31:0] xs();
        seed = step(seed);
        return seed;
    endfunction
    always @(negedge clk) begin
        st_seed <= step(st_seed);
        stall   <= st_seed[0] & st_seed[1];
    end

    mter_client_model client_u (
        .clk(clk), .stall(stall), .rx_valid(rx_valid), .rx_data(rx_data),
        .rx_last(rx_last), .rx_ready(rx_ready), .tx_valid(tx_valid),
        .tx_data(tx_data), .tx_last(tx_last), .tx_ready(tx_ready)
    );
    mter_responder dut_u (
        .clk(clk), .nrst(nrst), .rx_valid(rx_valid), .rx_data(rx_data),
        .rx_last(rx_last), .rx_ready(rx_ready), .tx_valid(tx_valid),
        .tx_data(tx_data), .tx_last(tx_last), .tx_ready(tx_ready),
        .op_busy(op_busy), .map_addr(map_addr), .map_rd_en(map_rd_en),
        .map_wr_en(map_wr_en), .map_wdata(map_wdata), .map_exists(in_obj),
        .map_readable(in_obj), .map_writable(in_obj && map_addr != 16'h604a),
        .map_value_ok(map_wdata != 16'hffff), .map_profile(in_obj || map_addr == 16'h604d),
        .map_obj_first(map_addr == 16'h6048), .map_multi(in_obj),
        .map_rdata(map_rdata)
    );

    // ****************************
    // checking helpers
    // ****************************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask
    // length counts unit id, function byte and body
    task automatic mk(output logic [7:0] q[$], input logic [15:0] tid, input logic [15:0] pid,
                      input logic [7:0] uid, input logic [7:0] fc, input logic [7:0] body[$]);
        q = {tid[15:8], tid[7:0], pid[15:8], pid[7:0], 8'h00, 8'(body.size() + 2), uid, fc};
        foreach (body[i]) q.push_back(body[i]);
    endtask
    task automatic run(input string name, input logic [7:0] qy[$], input logic [7:0] ex[$]);
        logic [7:0] got[$];
        bit         ok;
        client_u.send(qy, ok);
        check(32'(ok), 32'h1, "query accepted");
        client_u.recv(got, (ex.size() == 0) ? 40 : 80);
        check(got.size(), ex.size(), "response length");
        foreach (ex[i]) if (i < got.size()) check(got[i], ex[i], "response byte");
        $display("test %s done", name);
    endtask
    task automatic conclude();
        $display("comparisons %0d n_mismatch %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // ****************************
    // scenarios
    // ****************************
    initial begin
        logic [7:0]  qy[$];
        logic [7:0]  ex[$];
        logic [7:0]  bd[$];
        logic [15:0] w;
        logic [15:0] tid;
        static logic [15:0] e_adr [3] = '{16'h6050, 16'h6049, 16'h6049};
        static logic [15:0] e_dat [3] = '{16'h0001, 16'hffff, 16'h1234};
        static logic [7:0]  e_code [3] = '{8'h02, 8'h03, 8'h06};
        nrst    = 1'b0;
        op_busy = 1'b0;
        repeat (6) @(posedge clk);
        @(negedge clk) nrst = 1'b1;
        // four sub-indices, one protected: echo; six run into missing 604d: 02, object still written
        for (int k = 4; k < 8; k += 2) begin
            tid = 16'(xs());
            bd = {8'h60, 8'h48, 8'h00, 8'(k), 8'(2 * k)};
            for (int i = 0; i < k; i++) begin
                w = 16'(xs()) & 16'h7fff;
                bd.push_back(w[15:8]);
                bd.push_back(w[7:0]);
                if (i < 4 && i != 2) mem_ref[i] = int'(w);
            end
            mk(qy, tid, 16'h0000, 8'hff, 8'h10, bd);
            if (k == 4) begin
                mk(ex, tid, 16'h0000, 8'hff, 8'h10, bd[0:3]);
            end else begin
                bd = {8'h02};
                mk(ex, tid, 16'h0000, 8'hff, 8'h90, bd);
            end
            run((k == 4) ? "write four" : "write span", qy, ex);
        end
        // unsupported function, unit id zero echoed
        tid = 16'(xs());
        bd = {};
        mk(qy, tid, 16'h0000, 8'h00, 8'h05, bd);
        bd = {8'h01};
        mk(ex, tid, 16'h0000, 8'h00, 8'h85, bd);
        run("bad function", qy, ex);
        // missing, rejected value and busy exceptions
        for (int i = 0; i < 3; i++) begin
            tid = 16'(xs());
            @(negedge clk) op_busy = (i == 2);
            bd = {e_adr[i][15:8], e_adr[i][7:0], 8'h00, 8'h01, 8'h02, e_dat[i][15:8], e_dat[i][7:0]};
            mk(qy, tid, 16'h0000, 8'hff, 8'h10, bd);
            bd = {e_code[i]};
            mk(ex, tid, 16'h0000, 8'hff, 8'h90, bd);
            run("write exception", qy, ex);
        end
        @(negedge clk) op_busy = 1'b0;
        // read spanning a missing register: zero for it, no exception
        tid = 16'(xs());
        w = 16'(mem_ref[3]);
        bd = {8'h60, 8'h4b, 8'h00, 8'h02};
        mk(qy, tid, 16'h0000, 8'hff, 8'h03, bd);
        bd = {8'h04, w[15:8], w[7:0], 8'h00, 8'h00};
        mk(ex, tid, 16'h0000, 8'hff, 8'h03, bd);
        run("partial read", qy, ex);
        // non-zero protocol id, then unit id 01: silently dropped, nothing written
        bd = {8'h60, 8'h48, 8'h00, 8'h01, 8'h02, 8'h12, 8'h34};
        ex = {};
        for (int i = 0; i < 2; i++) begin
            mk(qy, 16'(xs()), 16'(1 - i), (i == 0) ? 8'hff : 8'h01, 8'h10, bd);
            run("dropped query", qy, ex);
        end
        // protected, rejected, busy and dropped writes left registers alone
        for (int i = 0; i < 4; i++) check(mem[i], 32'(mem_ref[i]), "register contents");
        check(32'(n_rd), 32'h2, "read walk pulses");
        conclude();
    end
endmodule // mter_responder_tb_top
`default_nettype wire
